// [hw/pdf_consts.svh]
// Register map, reset values and field positions of the port one I/O block
// Operation
// - Direction bit one makes its pin an output; zero makes it an input.
// - Direction register is write-only; reads return all ones without error.
// - Reset loads direction with 0x03 so the two lowest pins output clocks.
// - Hardware standby clears every direction bit, stopping both clock outputs.
// - Software standby keeps direction; outputs keep driving data or clock.
// - Data read gives latch for output pins, live pin level for inputs.
// - Two lowest pins as outputs drive system clock and E clock, not latch.
// - Reading the two lowest bits while clocking returns current clock levels.
// - Data bits one and zero are read-only; writes to them do nothing.
// - Reset clears data bits seven to two; bits one and zero undefined.
// - Single-chip mode: pins four, three, two are plain I/O only.
// - Interrupt enable makes its pin an interrupt input; data read gives pin level.
// - Bus release enable makes pins three and two request/grant, expanded only.
// - Control register reserved bits seven, two, one, zero ignore writes, read one.
// - Nonmaskable edge bit: zero falling edge (reset), one rising edge.
`ifndef PDF_CONSTS_SVH
`define PDF_CONSTS_SVH

`define PDF_ADDR_DIR        16'hfe80
`define PDF_ADDR_DATA       16'hfe82
`define PDF_ADDR_SYSCTL     16'hfefc
`define PDF_ADDR_MODE       16'hfe84
`define PDF_DIR_RESET       8'h03
`define PDF_DIR_STANDBY     8'h00
`define PDF_DATA_RESET      8'h00
`define PDF_DATA_WMASK      8'hfc
`define PDF_SYSCTL_RESET    8'h87
`define PDF_SYSCTL_FIXED    8'h87
`define PDF_SYSCTL_WMASK    8'h78
`define PDF_BIT_LINE1_EN    6
`define PDF_BIT_LINE0_EN    5
`define PDF_BIT_NMI_EDGE    4
`define PDF_BIT_BUS_REL     3
`define PDF_PIN_WAIT        4
`define PDF_PIN_BUS_REQ     3
`define PDF_PIN_BACK        2
`define PDF_PIN_IRQ1        6
`define PDF_PIN_IRQ0        5
`define PDF_ECLK_DIV        4'h8
`define PDF_HTRANS_NONSEQ   2'h2
`define PDF_HTRANS_SEQ      2'h3

`endif

// [hw/pdf_pkg.sv]
// Types shared by the port one I/O block
package pdf_pkg;

    typedef struct packed {
        logic [7:0] out;
        logic [7:0] oe;
    } pdf_pin_drive_t;

    typedef struct packed {
        logic        irq1_en;
        logic        irq0_en;
        logic        nmi_rising;
        logic        bus_release;
    } pdf_func_sel_t;

endpackage

// [hw/pdf_port1.sv]
// Port one general-purpose I/O with clock outputs and pin function select
`timescale 1ns/100ps
`include "pdf_consts.svh"

module pdf_port1
    import pdf_pkg::*;
#(
    parameter int                 WIDTH     = 8,
    parameter logic [3:0]         ECLK_DIV  = `PDF_ECLK_DIV
) (
    input  wire logic             mclk_i,
    input  wire logic             reset_i,
    // AHB-Lite slave
    input  wire logic             hsel_i,
    input  wire logic [15:0]      haddr_i,
    input  wire logic [1:0]       htrans_i,
    input  wire logic             hwrite_i,
    input  wire logic [2:0]       hsize_i,
    input  wire logic [31:0]      hwdata_i,
    input  wire logic             hready_i,
    output logic      [31:0]      hrdata_o,
    output logic                  hreadyout_o,
    output logic                  hresp_o,
    // Chip state
    input  wire logic             hw_standby_i,
    input  wire logic             sw_standby_i,
    input  wire logic             expanded_mode_i,
    // Pins
    input  wire logic [WIDTH-1:0] pin_i,
    output logic      [WIDTH-1:0] pin_o,
    output logic      [WIDTH-1:0] pin_oe_o,
    // Special functions routed to other blocks
    output logic                  line_one_irq_o,
    output logic                  line_zero_irq_o,
    output logic                  line_one_interrupt_enable_o,
    output logic                  line_zero_interrupt_enable_o,
    output logic                  nonmaskable_edge_select_o,
    output logic                  bus_request_input_o,
    output logic                  bus_release_active_o,
    input  wire logic             bus_grant_i,
    output logic                  sys_clk_o,
    output logic                  e_clk_o
);

    // ------------------------------------------------------------------
    // Registers
    // ------------------------------------------------------------------
    logic [7:0]  dir_r, dir_nxt;
    logic [7:0]  data_r, data_nxt;
    logic [7:0]  sysctl_r, sysctl_nxt;
    logic        wr_pend_r, wr_pend_nxt;
    logic [15:0] addr_r, addr_nxt;
    logic [31:0] rdata_r, rdata_nxt;
    logic [3:0]  ediv_r, ediv_nxt;
    logic        eclk_r, eclk_nxt;
    logic        sclk_r, sclk_nxt;
    pdf_pin_drive_t drive;
    pdf_func_sel_t  fsel;

    function automatic logic [7:0] read_mux(input logic [15:0] a,
                                            input logic [7:0]  dat);
        unique case (a)
            `PDF_ADDR_DIR:    read_mux = 8'hff;
            `PDF_ADDR_DATA:   read_mux = dat;
            `PDF_ADDR_SYSCTL: read_mux = sysctl_r | `PDF_SYSCTL_FIXED;
            `PDF_ADDR_MODE:   read_mux = {7'h00, expanded_mode_i};
            default:          read_mux = 8'h00;
        endcase
    endfunction

    // ------------------------------------------------------------------
    // Clock outputs
    // ------------------------------------------------------------------
    // System clock shows as a half-rate toggle
    always_comb begin
        sclk_nxt = ~sclk_r;
    end

    always_ff @(posedge mclk_i or posedge reset_i) begin
        if (reset_i) begin
            sclk_r <= 1'b0;
        end else begin
            sclk_r <= sclk_nxt;
        end
    end

    // E clock flips every ECLK_DIV cycles of the main clock
    always_comb begin
        ediv_nxt = ediv_r + 4'h1;
        eclk_nxt = eclk_r;
        if (ediv_r == ECLK_DIV - 4'h1) begin
            ediv_nxt = 4'h0;
            eclk_nxt = ~eclk_r;
        end
    end

    always_ff @(posedge mclk_i or posedge reset_i) begin
        if (reset_i) begin
            ediv_r <= 4'h0;
            eclk_r <= 1'b0;
        end else begin
            ediv_r <= ediv_nxt;
            eclk_r <= eclk_nxt;
        end
    end

    assign sys_clk_o = sclk_r;
    assign e_clk_o   = eclk_r;

    // ------------------------------------------------------------------
    // Function select
    // ------------------------------------------------------------------
    assign fsel.irq1_en     = sysctl_r[`PDF_BIT_LINE1_EN];
    assign fsel.irq0_en     = sysctl_r[`PDF_BIT_LINE0_EN];
    assign fsel.nmi_rising  = sysctl_r[`PDF_BIT_NMI_EDGE];
    assign fsel.bus_release = sysctl_r[`PDF_BIT_BUS_REL] & expanded_mode_i;

    assign line_one_interrupt_enable_o  = fsel.irq1_en;
    assign line_zero_interrupt_enable_o = fsel.irq0_en;
    assign nonmaskable_edge_select_o    = fsel.nmi_rising;
    assign bus_release_active_o         = fsel.bus_release;
    assign line_one_irq_o      = fsel.irq1_en & pin_i[`PDF_PIN_IRQ1];
    assign line_zero_irq_o     = fsel.irq0_en & pin_i[`PDF_PIN_IRQ0];
    assign bus_request_input_o = fsel.bus_release & pin_i[`PDF_PIN_BUS_REQ];

    // ------------------------------------------------------------------
    // Pin drive
    // ------------------------------------------------------------------
    // Pin map
    //   7      plain I/O
    //   6      plain I/O, or line one interrupt input when enabled
    //   5      plain I/O, or line zero interrupt input when enabled
    //   4      plain I/O; the wait input belongs to the wait controller
    //   3      plain I/O, or bus request input under bus release
    //   2      plain I/O, or bus grant output under bus release
    //   1      input, or E clock output when its direction bit is set
    //   0      input, or system clock output when its direction bit is set
    // Bus release only takes effect in expanded mode
    always_comb begin
        drive.out = data_r;
        drive.oe  = dir_r;
        drive.out[0] = sclk_r;
        drive.out[1] = eclk_r;
        if (fsel.irq1_en) begin
            drive.oe[`PDF_PIN_IRQ1] = 1'b0;
        end
        if (fsel.irq0_en) begin
            drive.oe[`PDF_PIN_IRQ0] = 1'b0;
        end
        if (fsel.bus_release) begin
            drive.oe[`PDF_PIN_BUS_REQ] = 1'b0;
            drive.oe[`PDF_PIN_BACK]  = 1'b1;
            drive.out[`PDF_PIN_BACK] = bus_grant_i;
        end
    end

    assign pin_o    = drive.out;
    assign pin_oe_o = drive.oe;

    // ------------------------------------------------------------------
    // AHB-Lite slave
    // ------------------------------------------------------------------
    logic       take;
    logic [7:0] pin_view;

    assign take = hsel_i & hready_i & (htrans_i == `PDF_HTRANS_NONSEQ |
                                       htrans_i == `PDF_HTRANS_SEQ);

    // Output pins read the latch, inputs the live pin; clock pins read the clock
    always_comb begin
        pin_view = (dir_r & data_r) | (~dir_r & pin_i);
        pin_view[0] = dir_r[0] ? sclk_r : pin_i[0];
        pin_view[1] = dir_r[1] ? eclk_r : pin_i[1];
        if (fsel.irq1_en) begin
            pin_view[`PDF_PIN_IRQ1] = pin_i[`PDF_PIN_IRQ1];
        end
        if (fsel.irq0_en) begin
            pin_view[`PDF_PIN_IRQ0] = pin_i[`PDF_PIN_IRQ0];
        end
    end

    // ------------------------------------------------------------------
    // Bus address phase
    // ------------------------------------------------------------------
    // The address phase is held over so a write lands with its data phase
    // Reads need no hold-over: their word is captured at once
    always_comb begin
        wr_pend_nxt = take & hwrite_i;
        addr_nxt    = addr_r;
        if (take) begin
            addr_nxt = haddr_i;
        end
    end

    always_ff @(posedge mclk_i or posedge reset_i) begin
        if (reset_i) begin
            wr_pend_r <= 1'b0;
            addr_r    <= 16'h0000;
        end else begin
            wr_pend_r <= wr_pend_nxt;
            addr_r    <= addr_nxt;
        end
    end

    // True in the data phase of a write to the given register
    function automatic logic wr_hit(input logic [15:0] a);
        wr_hit = wr_pend_r & (addr_r == a);
    endfunction

    // ------------------------------------------------------------------
    // Direction register
    // ------------------------------------------------------------------
    // Hardware standby wins over a write in the same cycle
    always_comb begin
        dir_nxt = dir_r;
        if (wr_hit(`PDF_ADDR_DIR)) begin
            dir_nxt = hwdata_i[7:0];
        end
        if (hw_standby_i) begin
            dir_nxt = `PDF_DIR_STANDBY;
        end
    end

    always_ff @(posedge mclk_i or posedge reset_i) begin
        if (reset_i) begin
            dir_r <= `PDF_DIR_RESET;
        end else begin
            dir_r <= dir_nxt;
        end
    end

    // ------------------------------------------------------------------
    // Data latch
    // ------------------------------------------------------------------
    // Bits one and zero keep their value; the clocks own those pins
    always_comb begin
        data_nxt = data_r;
        if (wr_hit(`PDF_ADDR_DATA)) begin
            data_nxt = (data_r & ~`PDF_DATA_WMASK)
                     | (hwdata_i[7:0] & `PDF_DATA_WMASK);
        end
    end

    always_ff @(posedge mclk_i or posedge reset_i) begin
        if (reset_i) begin
            data_r <= `PDF_DATA_RESET;
        end else begin
            data_r <= data_nxt;
        end
    end

    // ------------------------------------------------------------------
    // Control register
    // ------------------------------------------------------------------
    // Reserved bits are forced to one on every write
    always_comb begin
        sysctl_nxt = sysctl_r;
        if (wr_hit(`PDF_ADDR_SYSCTL)) begin
            sysctl_nxt = (hwdata_i[7:0] & `PDF_SYSCTL_WMASK)
                       | `PDF_SYSCTL_FIXED;
        end
        // Hardware standby reinitialises it like a reset
        if (hw_standby_i) begin
            sysctl_nxt = `PDF_SYSCTL_RESET;
        end
    end

    always_ff @(posedge mclk_i or posedge reset_i) begin
        if (reset_i) begin
            sysctl_r <= `PDF_SYSCTL_RESET;
        end else begin
            sysctl_r <= sysctl_nxt;
        end
    end

    // ------------------------------------------------------------------
    // Read data
    // ------------------------------------------------------------------
    // Captured in the address phase so the data phase sees a settled word
    always_comb begin
        rdata_nxt = rdata_r;
        if (take & ~hwrite_i) begin
            rdata_nxt = {24'h000000, read_mux(haddr_i, pin_view)};
        end
    end

    always_ff @(posedge mclk_i or posedge reset_i) begin
        if (reset_i) begin
            rdata_r <= 32'h00000000;
        end else begin
            rdata_r <= rdata_nxt;
        end
    end

    // Zero wait states, always OKAY
    // Read data therefore stands one cycle after its address phase
    assign hreadyout_o = 1'b1;
    assign hresp_o     = 1'b0;
    assign hrdata_o    = rdata_r;

endmodule

// [testbench/pdf_port1_properties.sv]
// Concurrent checks on the port one block
`timescale 1ns/100ps
module pdf_port1_props #(parameter int WIDTH = 8) (
    input wire logic             mclk_i,
    input wire logic             reset_i,
    input wire logic             hsel_i,
    input wire logic [15:0]      haddr_i,
    input wire logic [1:0]       htrans_i,
    input wire logic             hwrite_i,
    input wire logic             hready_i,
    input wire logic [31:0]      hwdata_i,
    input wire logic [31:0]      hrdata_o,
    input wire logic             hw_standby_i,
    input wire logic             expanded_mode_i,
    input wire logic [WIDTH-1:0] pin_o,
    input wire logic [WIDTH-1:0] pin_oe_o,
    input wire logic             bus_release_active_o,
    input wire logic             bus_grant_i,
    input wire logic             sys_clk_o
);
    default clocking @(posedge mclk_i); endclocking
    default disable iff (reset_i);
    sequence s_rd(a);
        hsel_i && hready_i && htrans_i[1] && !hwrite_i && haddr_i == a;
    endsequence
    sequence s_wr(a);
        hsel_i && hready_i && htrans_i[1] && hwrite_i && haddr_i == a ##1 hready_i;
    endsequence
    a_dir_reads_ones: assert property (s_rd(16'hfe80) |=> hrdata_o == 32'hff)
        else $error("direction read not all ones");
    a_ctl_fixed_ones: assert property (s_rd(16'hfefc) |=> (hrdata_o & 32'h87) == 32'h87)
        else $error("reserved control bits not one");
    a_hw_standby_clr: assert property (hw_standby_i |=> pin_oe_o == 8'h00)
        else $error("standby left a pin driving");
    a_write_lands: assert property (s_wr(16'hfe82) ##0 pin_oe_o[7] |=> pin_o[7] == $past(hwdata_i[7]))
        else $error("data write not on pin");
    a_clock_read: assert property (s_rd(16'hfe82) ##0 pin_oe_o[0] |=> hrdata_o[0] == $past(sys_clk_o))
        else $error("clock level not read");
    a_latch_read: assert property (s_rd(16'hfe82) ##0 pin_oe_o[7] |=> hrdata_o[7] == $past(pin_o[7]))
        else $error("output pin read not latch");
    a_sys_clk_pin: assert property (pin_oe_o[0] |-> pin_o[0] == sys_clk_o)
        else $error("clock pin not system clock");
    a_bus_release: assert property (bus_release_active_o |-> expanded_mode_i && pin_oe_o[3:2] == 2'b01 && pin_o[2] == bus_grant_i)
        else $error("bus release pins wrong");
endmodule

bind pdf_port1 pdf_port1_props #(.WIDTH(WIDTH)) props_u (.*);

// [testbench/pdf_board.sv]
// Board model on the eight port pins
`timescale 1ns/100ps
module pdf_board (
    input  wire logic [7:0] drv_i,
    input  wire logic [7:0] oe_i,
    input  wire logic [7:0] ext_i,
    output logic      [7:0] lvl_o
);
    // Driven pins carry the block's level, the rest the board's own
    assign lvl_o = (oe_i & drv_i) | (~oe_i & ext_i);
endmodule

// [testbench/pdf_port1_test.sv]
// Self-checking bench for the port one block
`timescale 1ns/100ps
`define CHK(g, e) begin tests_run++; if ((g) !== (e)) begin n_errors++; \
    $display("[FAIL] %0t got %h exp %h", $time, (g), (e)); end end
module pdf_port1_test;
    logic        mclk_i = 0, reset_i = 1, hsel_i = 0, hwrite_i = 0;
    logic        hw_sb = 0, sw_sb = 0, exp_m = 0, grant = 1;
    logic [15:0] haddr_i = 0;
    logic [1:0]  htrans_i = 0;
    logic [31:0] hwdata_i = 0, hrdata_o, r;
    logic [7:0]  ext = 8'h5c, pin_i, pin_o, pin_oe_o;
    logic        nmi_edge, brl, sclk, eclk;
    logic        irq1, irq0, ie1, ie0, bus_request_input, resp;
    wire         hready;
    int          n_errors = 0;
    int          tests_run = 0;
    pdf_port1 dut_u (.mclk_i(mclk_i), .reset_i(reset_i), .hsel_i(hsel_i), .haddr_i(haddr_i),
        .htrans_i(htrans_i), .hwrite_i(hwrite_i), .hsize_i(3'h2), .hwdata_i(hwdata_i),
        .hready_i(hready), .hrdata_o(hrdata_o), .hreadyout_o(hready), .hresp_o(resp),
        .hw_standby_i(hw_sb), .sw_standby_i(sw_sb), .expanded_mode_i(exp_m), .pin_i(pin_i),
        .pin_o(pin_o), .pin_oe_o(pin_oe_o), .line_one_irq_o(irq1), .line_zero_irq_o(irq0),
        .line_one_interrupt_enable_o(ie1), .line_zero_interrupt_enable_o(ie0),
        .nonmaskable_edge_select_o(nmi_edge), .bus_request_input_o(bus_request_input),
        .bus_release_active_o(brl), .bus_grant_i(grant), .sys_clk_o(sclk), .e_clk_o(eclk));
    pdf_board board_u (.drv_i(pin_o), .oe_i(pin_oe_o), .ext_i(ext), .lvl_o(pin_i));

    initial begin
        forever #2 mclk_i = ~mclk_i;
    end

    task automatic conclude();
        $display("comparisons %0d mismatches %0d", tests_run, n_errors);
        if (n_errors == 0 && tests_run > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask

    // One single transfer: address phase, then data phase
    task automatic bus(input logic [15:0] a, input logic w, input logic [7:0] d);
        int n;
        n = 0;
        @(posedge mclk_i);
        hsel_i <= 1'b1;
        haddr_i <= a;
        htrans_i <= 2'h2;
        hwrite_i <= w;
        do begin @(posedge mclk_i); n++; end while (hready !== 1'b1 && n < 20);
        hsel_i <= 1'b0;
        htrans_i <= 2'h0;
        hwdata_i <= {24'h0, d};
        do begin @(posedge mclk_i); n++; end while (hready !== 1'b1 && n < 20);
        r = hrdata_o;
        if (n >= 20) begin
            n_errors++;
            conclude();
        end
        #1;
    endtask

    task automatic t_reset();
        `CHK(pin_oe_o, 8'h03)
        `CHK(nmi_edge, 1'b0)
        bus(16'hfefc, 0, 0);
        `CHK(r, 32'h87)
        bus(16'hfe90, 0, 0);
        `CHK(r, 32'h0)
        `CHK(resp, 1'b0)
        `CHK({ie1, ie0}, 2'b00)
        bus(16'hfe80, 1, 8'hff);
        bus(16'hfe82, 0, 0);
        `CHK(r[7:2], 6'h00)
    endtask

    task automatic t_dir();
        logic [7:0] tbl[3] = '{8'h5a, 8'ha5, 8'hf3};
        foreach (tbl[i]) begin
            bus(16'hfe80, 1, tbl[i]);
            `CHK(pin_oe_o, tbl[i])
            bus(16'hfe80, 0, 0);
            `CHK(r, 32'hff)
        end
    endtask

    task automatic t_data();
        bus(16'hfe82, 1, 8'ha6);
        `CHK(pin_o[7:2], 6'h29)
        `CHK(pin_o[1:0], {eclk, sclk})
        bus(16'hfe82, 0, 0);
        `CHK(r[7:2], 6'h2b)
    endtask

    task automatic t_func();
        bus(16'hfe80, 1, 8'hff);
        bus(16'hfefc, 1, 8'h78);
        bus(16'hfefc, 0, 0);
        `CHK(r, 32'hff)
        `CHK(nmi_edge, 1'b1)
        `CHK({ie1, ie0, irq1, irq0}, 4'b1110)
        `CHK(pin_oe_o[6:5], 2'b00)
        `CHK({brl, pin_oe_o[3:2]}, 3'b011)
        bus(16'hfe82, 0, 0);
        `CHK(r[6:5], ext[6:5])
        @(posedge mclk_i);
        exp_m <= 1'b1;
        grant <= 1'b0;
        bus(16'hfe84, 0, 0);
        `CHK({brl, pin_oe_o[3:2], pin_o[2]}, 4'b1010)
        `CHK({bus_request_input, r}, {1'b1, 32'h1})
        bus(16'hfefc, 1, 8'h00);
        bus(16'hfefc, 0, 0);
        `CHK(r, 32'h87)
    endtask

    task automatic t_standby();
        @(posedge mclk_i);
        sw_sb <= 1'b1;
        repeat (4) @(posedge mclk_i);
        #1;
        `CHK({pin_oe_o, pin_o[7:2]}, {8'hff, 6'h29})
        @(posedge mclk_i);
        hw_sb <= 1'b1;
        repeat (2) @(posedge mclk_i);
        #1;
        `CHK(pin_oe_o, 8'h00)
        @(posedge mclk_i);
        hw_sb <= 1'b0;
        sw_sb <= 1'b0;
    endtask

    initial begin
        repeat (20) @(posedge mclk_i);
        reset_i <= 1'b0;
        #1;
        t_reset();
        t_dir();
        t_data();
        t_func();
        t_standby();
        conclude();
    end
endmodule
